// ---- src/wave_timing_pkg.sv ----
// Constants, register map and carrier types for the waveform and counter timing block.
// Assumes a 25 MHz core clock and a plain one-cycle register port.
package wave_timing_pkg;
	localparam int CLK_NS = 40;
	localparam int TRIG_PW_NS = 50;
	localparam int TRIG_PW_CYC = (TRIG_PW_NS + CLK_NS - 1) / CLK_NS;
	localparam int UPD_PW_NS = 300;
	localparam int UPD_PW_CYC = (UPD_PW_NS + CLK_NS - 1) / CLK_NS;
	localparam int CLK_KHZ = 25000;
	localparam int SLOW_KHZ = 100;
	localparam int SLOW_DIV = CLK_KHZ / SLOW_KHZ;
	localparam logic [3:0] FAST_STEP = 4'h4;
	localparam logic [3:0] FAST_MOD = 4'h5;
	// Register word addresses
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_ROUTE0 = 8'h01;
	localparam logic [7:0] A_UI = 8'h08;
	localparam logic [7:0] A_CFG0 = 8'h09;
	localparam logic [7:0] A_CNT0 = 8'h0b;
	localparam logic [7:0] A_STAT = 8'h0d;
	// Control register fields
	localparam int C_SWGATE = 0;
	localparam int C_STOP = 1;
	localparam int C_SLOW = 2;
	localparam int C_POSTED = 3;
	localparam int C_ARM = 4;
	localparam int C_OE = 8;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	// Routed sources
	localparam int R_TRIG = 0;
	localparam int R_UPD = 1;
	localparam int R_UICLK = 2;
	localparam int R_C0CLK = 3;
	localparam int R_C0GATE = 4;
	localparam int NROUTE = 7;
	// Driven pins
	localparam int P_TRIG = 0;
	localparam int P_UPD = 1;
	localparam int P_C0CLK = 2;
	localparam int P_C0GATE = 3;
	localparam int P_C0OUT = 6;
	localparam int NPOUT = 8;
	typedef struct packed {
		logic ext;
		logic pol;
		logic [3:0] pin;
	} route_s;
	localparam route_s ROUTE_RST = 6'h00;
	typedef struct packed {
		logic gate_start;
		logic sw_up;
		logic ext_dir;
		logic out_pol;
		logic toggle;
		logic enable;
		logic [15:0] reload;
	} cnt_cfg_s;
	localparam cnt_cfg_s CFG_RST = 22'h000000;
	localparam logic [15:0] UI_RST = 16'h0000;
	typedef enum logic [1:0] {WF_IDLE, WF_ARMED, WF_RUN} wf_state_e;
endpackage

// ---- src/wave_timing.sv ----
// Waveform trigger/update timing, update-interval counter and two general counters.
// Assumes pin inputs synchronous to i_core_clk; host drives a one-cycle register port.
// Behaviour
// - Selected pin edge starts waveform generation
// - Trigger starts interval counter when internal
// - Trigger out: high pulse, 50-100 ns
// - All timing outputs disabled until software enables
// - Selected pin edge updates DACs, posted mode
// - Applied update out: low pulse 300-350 ns
// - DACs update within 100 ns of strobe; code sets o_dac_update on third clock edge after pin edge, up to 120 ns
// - Interval counter makes updates; stop or buffer-done
// - Software gate suppresses all DAC updates
// - Interval clock from pin, level, polarity; code counts selected pin edges
// - Internal timebase 20 MHz or 100 kHz
// - Counter clock from pin edge, monitored out
// - Counter gate from pin edge, start/latch
// - Actual counter gate driven to monitor pin
// - Counter output pulse or toggle, polarity
// - Counter zero direction pin: low down
// - Direction pin disabled: software sets direction
// - Counter one direction pin: low down
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ns
module wave_timing
	import wave_timing_pkg::*;
#(
	parameter int NPIN = 10
)
(
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic [NPIN-1:0] i_pfi,
	input wire logic i_digital_line_six,
	input wire logic i_digital_line_seven,
	input wire logic i_buffer_done,
	output logic o_dac_update,
	output logic [NPOUT-1:0] o_pin,
	output logic [NPOUT-1:0] o_pin_oe
);
	if (NPIN < 1 || NPIN > 16)
	begin : g_chk
		$error("NPIN must be 1 to 16");
	end

	logic [NPIN-1:0] s1_q, s2_q, s3_q;
	logic [15:0] lvl_now, lvl_prev;
	logic [15:0] ctrl_q;
	route_s route_q [NROUTE];
	logic [15:0] ui_reload_q, ui_cnt_q;
	cnt_cfg_s cfg_q [2];
	logic [15:0] cnt_q [2];
	logic [15:0] latch_q [2];
	logic gate_run_q [2];
	logic cmon_q [2];
	logic gmon_q [2];
	logic cout_q [2];
	logic lvl [NROUTE];
	logic evt [NROUTE];
	logic [3:0] fast_acc_q;
	logic [7:0] slow_cnt_q;
	logic fast_en, slow_en, tb_tick;
	wf_state_e wf_q;
	logic done_q;
	logic [7:0] trig_cnt_q, upd_cnt_q;
	logic trig_q, updpin_q;
	logic wr_ctrl, trig_used, upd_src, upd_apply;
	logic [4:0] dirs;

	// Two-stage synchroniser plus history stage per pin
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end
		else
		begin
			s1_q <= i_pfi;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	assign lvl_now = 16'(s2_q);
	assign lvl_prev = 16'(s3_q);

	// Per-source pin select, polarity and edge strobe
	for (genvar k = 0; k < NROUTE; k++)
	begin : g_route
		localparam logic [7:0] AR = A_ROUTE0 + 8'(k);
		assign lvl[k] = route_q[k].ext & (lvl_now[route_q[k].pin] ^ route_q[k].pol);
		assign evt[k] = lvl[k] & ~(lvl_prev[route_q[k].pin] ^ route_q[k].pol);
		always_ff @(posedge i_core_clk or negedge i_nrst)
		begin
			if (!i_nrst)
				route_q[k] <= ROUTE_RST;
			else if (i_wr && i_addr == AR)
				route_q[k] <= i_wdata[5:0];
		end
	end

	// Internal timebases as enables
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			fast_acc_q <= '0;
			slow_cnt_q <= '0;
		end
		else
		begin
			fast_acc_q <= fast_en ? fast_acc_q + FAST_STEP - FAST_MOD : fast_acc_q + FAST_STEP;
			slow_cnt_q <= slow_en ? '0 : slow_cnt_q + 8'h01;
		end
	end
	assign fast_en = (fast_acc_q + FAST_STEP) >= FAST_MOD;
	assign slow_en = slow_cnt_q == 8'(SLOW_DIV - 1);
	assign tb_tick = ctrl_q[C_SLOW] ? slow_en : fast_en;

	// Register writes
	assign wr_ctrl = i_wr && i_addr == A_CTRL;
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			ctrl_q <= CTRL_RST;
			ui_reload_q <= UI_RST;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_q <= {i_wdata[15:C_OE], 3'h0, 1'b0, i_wdata[C_POSTED:C_SLOW], 1'b0,
					i_wdata[C_SWGATE]};
			if (i_wr && i_addr == A_UI)
				ui_reload_q <= i_wdata[15:0];
		end
	end
	assign o_pin_oe = ctrl_q[C_OE +: NPOUT];

	// Waveform sequence
	assign trig_used = wf_q == WF_ARMED && evt[R_TRIG];
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			wf_q <= WF_IDLE;
			done_q <= 1'b0;
		end
		else
		begin
			unique case (wf_q)
				WF_IDLE:
					if (wr_ctrl && i_wdata[C_ARM])
						wf_q <= WF_ARMED;
				WF_ARMED:
					if (wr_ctrl && i_wdata[C_STOP])
						wf_q <= WF_IDLE;
					else if (trig_used)
						wf_q <= WF_RUN;
				WF_RUN:
					if ((wr_ctrl && i_wdata[C_STOP]) || i_buffer_done)
						wf_q <= WF_IDLE;
			endcase
			if (wf_q == WF_RUN && i_buffer_done)
				done_q <= 1'b1;
			else if (wr_ctrl && i_wdata[C_ARM])
				done_q <= 1'b0;
		end
	end

	// Update-interval counter, internally timed updates
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			ui_cnt_q <= '0;
		else if (trig_used)
			ui_cnt_q <= ui_reload_q;
		else if (wf_q == WF_RUN && !route_q[R_UPD].ext &&
			(route_q[R_UICLK].ext ? evt[R_UICLK] : tb_tick))
			ui_cnt_q <= ui_cnt_q == '0 ? ui_reload_q : ui_cnt_q - 16'h0001;
	end
	assign upd_src = route_q[R_UPD].ext ? evt[R_UPD] && ctrl_q[C_POSTED]
		: route_q[R_UICLK].ext ? evt[R_UICLK] && ui_cnt_q == '0
		: tb_tick && ui_cnt_q == '0;
	assign upd_apply = wf_q == WF_RUN && upd_src && !ctrl_q[C_SWGATE];

	// DAC strobe and pin pulses
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_dac_update <= 1'b0;
			trig_cnt_q <= '0;
			upd_cnt_q <= '0;
			trig_q <= 1'b0;
			updpin_q <= 1'b1;
		end
		else
		begin
			o_dac_update <= upd_apply;
			if (trig_used)
				trig_cnt_q <= 8'(TRIG_PW_CYC);
			else if (trig_cnt_q != '0)
				trig_cnt_q <= trig_cnt_q - 8'h01;
			trig_q <= trig_used || trig_cnt_q > 8'h01;
			if (upd_apply)
				upd_cnt_q <= 8'(UPD_PW_CYC);
			else if (upd_cnt_q != '0)
				upd_cnt_q <= upd_cnt_q - 8'h01;
			updpin_q <= !(upd_apply || upd_cnt_q > 8'h01);
		end
	end

	// General-purpose counters
	assign dirs = {i_digital_line_seven, i_digital_line_six, 3'h0};
	for (genvar k = 0; k < 2; k++)
	begin : g_cnt
		localparam int RC = R_C0CLK + 2 * k;
		localparam int RG = R_C0GATE + 2 * k;
		localparam logic [7:0] AC = A_CFG0 + 8'(k);
		logic tick, up, tc;
		cnt_cfg_s wcfg;
		assign wcfg = i_wdata[21:0];
		assign tick = route_q[RC].ext ? evt[RC] : tb_tick;
		assign up = cfg_q[k].ext_dir ? dirs[3 + k] : cfg_q[k].sw_up;
		assign tc = tick && cfg_q[k].enable && (gate_run_q[k] || !cfg_q[k].gate_start)
			&& (up ? cnt_q[k] == cfg_q[k].reload : cnt_q[k] == '0);
		always_ff @(posedge i_core_clk or negedge i_nrst)
		begin
			if (!i_nrst)
			begin
				cfg_q[k] <= CFG_RST;
				cnt_q[k] <= '0;
				latch_q[k] <= '0;
				gate_run_q[k] <= 1'b0;
				cmon_q[k] <= 1'b0;
				gmon_q[k] <= 1'b0;
				cout_q[k] <= 1'b0;
			end
			else
			begin
				if (i_wr && i_addr == AC)
				begin
					cfg_q[k] <= i_wdata[21:0];
					cnt_q[k] <= i_wdata[15:0];
					gate_run_q[k] <= 1'b0;
				end
				else if (tick && cfg_q[k].enable && (gate_run_q[k] || !cfg_q[k].gate_start))
				begin
					if (tc)
						cnt_q[k] <= up ? '0 : cfg_q[k].reload;
					else
						cnt_q[k] <= up ? cnt_q[k] + 16'h0001 : cnt_q[k] - 16'h0001;
				end
				if (evt[RG])
				begin
					gate_run_q[k] <= !gate_run_q[k];
					latch_q[k] <= cnt_q[k];
				end
				cmon_q[k] <= route_q[RC].ext ? lvl[RC] : cmon_q[k] ^ tb_tick;
				gmon_q[k] <= lvl[RG];
				if (i_wr && i_addr == AC)
					cout_q[k] <= wcfg.out_pol;
				else if (cfg_q[k].toggle)
					cout_q[k] <= cout_q[k] ^ tc;
				else
					cout_q[k] <= tc ^ cfg_q[k].out_pol;
			end
		end
		assign o_pin[P_C0CLK + 2 * k] = cmon_q[k];
		assign o_pin[P_C0GATE + 2 * k] = gmon_q[k];
		assign o_pin[P_C0OUT + k] = cout_q[k];
	end
	assign o_pin[P_TRIG] = trig_q;
	assign o_pin[P_UPD] = updpin_q;

	// Register reads, one cycle later
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			o_rdata <= '0;
		else if (i_rd)
		begin
			o_rdata <= '0;
			if (i_addr == A_CTRL)
				o_rdata <= 32'(ctrl_q);
			else if (i_addr >= A_ROUTE0 && i_addr < A_ROUTE0 + 8'(NROUTE))
				o_rdata <= 32'(route_q[3'(i_addr - A_ROUTE0)]);
			else if (i_addr == A_UI)
				o_rdata <= {ui_cnt_q, ui_reload_q};
			else if (i_addr == A_CFG0 || i_addr == A_CFG0 + 8'h01)
				o_rdata <= 32'(cfg_q[i_addr[0] ^ A_CFG0[0]]);
			else if (i_addr == A_CNT0 || i_addr == A_CNT0 + 8'h01)
				o_rdata <= {latch_q[i_addr[0] ^ A_CNT0[0]], cnt_q[i_addr[0] ^ A_CNT0[0]]};
			else if (i_addr == A_STAT)
				o_rdata <= {28'h0000000, gate_run_q[1], gate_run_q[0], done_q,
					wf_q == WF_RUN};
		end
	end
endmodule

// ---- test/pfi_model.sv ----
// Outside instrument driving the programmable function pins.
// Assumes the bench calls its tasks; levels change just after a clock edge.
`timescale 1ns/1ns
module pfi_model
(
	input wire logic i_core_clk,
	output logic [9:0] o_pfi
);
	initial o_pfi = 10'h000;
	// Whole-cycle levels, 40 ns each way
	task automatic drive(input int b, input logic v);
		@(posedge i_core_clk);
		o_pfi[b] <= v;
	endtask
	// Strobes spaced 18 cycles apart
	task automatic pulse(input int b);
		drive(b, 1'b1);
		repeat (8) @(posedge i_core_clk);
		drive(b, 1'b0);
		repeat (8) @(posedge i_core_clk);
	endtask
endmodule

// ---- test/wave_timing_monitor.sv ----
// Assertions on the timing block's register port and pin outputs.
// Assumes binding into wave_timing; one clock domain.
`timescale 1ns/1ns
module wave_timing_monitor
	import wave_timing_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_buffer_done,
	input wire logic o_dac_update,
	input wire logic [NPOUT-1:0] o_pin,
	input wire logic [NPOUT-1:0] o_pin_oe
);
	logic gate_q;
	logic ctrl_wr;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);
	assign ctrl_wr = i_wr && i_addr == A_CTRL;
	// Software gate as last written
	always_ff @(posedge i_core_clk or negedge i_nrst)
		if (!i_nrst)
			gate_q <= 1'b0;
		else if (ctrl_wr)
			gate_q <= i_wdata[C_SWGATE];
	sequence s_trig_tail;
		o_pin[P_TRIG] ##1 !o_pin[P_TRIG];
	endsequence
	sequence s_upd_low;
		o_dac_update ##1 (!o_pin[P_UPD])[*7];
	endsequence
	sequence s_quiet;
		(!o_dac_update)[*4];
	endsequence
	property p_oe_hold; !$stable(o_pin_oe) |-> $past(ctrl_wr); endproperty
	property p_oe_set; ctrl_wr |=> o_pin_oe == $past(i_wdata[15:8]); endproperty
	property p_trig; $rose(o_pin[P_TRIG]) |=> s_trig_tail; endproperty
	property p_upd; $fell(o_pin[P_UPD]) |-> s_upd_low; endproperty
	property p_upd_pin; o_dac_update |-> !o_pin[P_UPD]; endproperty
	property p_gate; $past(gate_q) |-> !o_dac_update; endproperty
	property p_stop; ctrl_wr && i_wdata[C_STOP] |-> ##2 s_quiet; endproperty
	property p_done; $rose(i_buffer_done) |-> ##2 s_quiet; endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("oe changed");
	a_oe_set: assert property (p_oe_set) else $error("oe value");
	a_trig: assert property (p_trig) else $error("trigger width");
	a_upd: assert property (p_upd) else $error("update width");
	a_upd_pin: assert property (p_upd_pin) else $error("update pin");
	a_gate: assert property (p_gate) else $error("gated update");
	a_stop: assert property (p_stop) else $error("update after stop");
	a_done: assert property (p_done) else $error("update after done");
endmodule
bind wave_timing wave_timing_monitor u_wave_timing_monitor (.i_core_clk(i_core_clk),
	.i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
	.i_buffer_done(i_buffer_done), .o_dac_update(o_dac_update), .o_pin(o_pin),
	.o_pin_oe(o_pin_oe));

// ---- test/wave_timing_tb.sv ----
// Self-checking bench for the waveform and counter timing block.
// Assumes pfi_model drives the pins; the host port is driven here.
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end
module wave_timing_tb import wave_timing_pkg::*;;
	logic i_core_clk;
	logic i_nrst = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_digital_line_six = 1'b0;
	logic i_digital_line_seven = 1'b0;
	logic i_buffer_done = 1'b0;
	wire logic [9:0] i_pfi;
	logic [31:0] o_rdata;
	logic o_dac_update;
	logic [7:0] o_pin;
	logic [7:0] o_pin_oe;
	int num_errors = 0;
	int check_count = 0;
	int n;
	logic [31:0] d;
	logic s;
	wave_timing #(.NPIN(10)) u_wave_timing (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_pfi(i_pfi), .i_digital_line_six(i_digital_line_six),
		.i_digital_line_seven(i_digital_line_seven), .i_buffer_done(i_buffer_done),
		.o_dac_update(o_dac_update), .o_pin(o_pin), .o_pin_oe(o_pin_oe));
	pfi_model u_pfi_model (.i_core_clk(i_core_clk), .o_pfi(i_pfi));
	initial
	begin
		i_core_clk = 1'b0;
		forever #20 i_core_clk = ~i_core_clk;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge i_core_clk);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge i_core_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
	endtask
	task automatic cnt(input int c, output int k);
		k = 0;
		repeat (c)
		begin
			@(posedge i_core_clk);
			#1 k += (o_dac_update === 1'b1);
		end
	endtask
	task automatic look(input int b, output logic z);
		z = 1'b0;
		repeat (8)
		begin
			@(posedge i_core_clk);
			#1 z |= (o_pin[b] === 1'b1);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// About five times the expected run
	initial
	begin
		repeat (10000) @(posedge i_core_clk);
		num_errors++;
		close_out();
	end
	initial
	begin
		repeat (5) @(posedge i_core_clk);
		i_nrst <= 1'b1;
		#1;
		`CHK("oe", 8'h00, o_pin_oe)
		`CHK("pins", 8'h02, o_pin)
		wr(8'h20, 32'hffffffff);
		rd(8'h20, d);
		`CHK("unmapped", 32'h0, d)
		wr(A_CTRL, 32'h0000ff00);
		`CHK("oe on", 8'hff, o_pin_oe)
		$display("test reset done");
		wr(A_UI, 32'h3);
		wr(A_ROUTE0, 32'h33);
		wr(A_CTRL, 32'h0000ff10);
		u_pfi_model.drive(3, 1'b1);
		look(P_TRIG, s);
		`CHK("rise", 1'b0, s)
		u_pfi_model.drive(3, 1'b0);
		look(P_TRIG, s);
		`CHK("fall", 1'b1, s)
		rd(A_STAT, d);
		`CHK("run", 1'b1, d[0])
		$display("test trigger done");
		cnt(200, n);
		`CHK("fast", 1'b1, n >= 39 && n <= 41)
		wr(A_UI, 32'h0);
		cnt(20, n);
		wr(A_CTRL, 32'h0000ff04);
		cnt(1000, n);
		`CHK("slow", 1'b1, n >= 3 && n <= 5)
		wr(A_CTRL, 32'h0000ff01);
		cnt(50, n);
		`CHK("gated", 0, n)
		wr(A_CTRL, 32'h0000ff02);
		cnt(50, n);
		`CHK("stopped", 0, n)
		rd(A_STAT, d);
		`CHK("idle", 1'b0, d[0])
		$display("test interval done");
		wr(A_ROUTE0 + 8'h01, 32'h25);
		wr(A_CTRL, 32'h0000ff10);
		u_pfi_model.pulse(3);
		fork
			u_pfi_model.pulse(5);
			cnt(20, n);
		join
		`CHK("unposted", 0, n)
		wr(A_CTRL, 32'h0000ff08);
		fork
			u_pfi_model.pulse(5);
			cnt(20, n);
		join
		`CHK("posted", 1, n)
		// One-cycle buffer done pulse after the posted strobe
		@(posedge i_core_clk);
		i_buffer_done <= 1'b1;
		@(posedge i_core_clk);
		i_buffer_done <= 1'b0;
		rd(A_STAT, d);
		`CHK("done", 2'b10, d[1:0])
		$display("test external done");
		for (int k = 0; k < 8; k++)
		begin
			i_digital_line_six <= k[0];
			i_digital_line_seven <= k[0];
			wr(A_CFG0 + {7'h00, k[2]}, {11'h000, ~k[0], k[1], 2'h0, 1'b1, 16'h00ff});
			repeat (20) @(posedge i_core_clk);
			rd(A_CNT0 + {7'h00, k[2]}, d);
			`CHK("up", k[0] ~^ k[1], d[15:0] < 16'h0080)
		end
		$display("test direction done");
		wr(A_ROUTE0 + 8'h05, 32'h27);
		wr(A_CFG0 + 8'h01, 32'h00070000);
		`CHK("toggle idle", 1'b1, o_pin[P_C0OUT + 1])
		wr(A_ROUTE0 + 8'h03, 32'h27);
		wr(A_ROUTE0 + 8'h04, 32'h28);
		wr(A_CFG0, 32'h00210002);
		fork
			u_pfi_model.pulse(7);
			look(P_C0CLK, s);
		join
		`CHK("clock mon", 1'b1, s)
		`CHK("toggled", 1'b0, o_pin[P_C0OUT + 1])
		rd(A_CNT0, d);
		`CHK("held", 16'h0002, d[15:0])
		u_pfi_model.drive(8, 1'b1);
		look(P_C0GATE, s);
		`CHK("gate mon", 1'b1, s)
		u_pfi_model.pulse(7);
		u_pfi_model.pulse(7);
		fork
			u_pfi_model.pulse(7);
			look(P_C0OUT, s);
		join
		`CHK("tc pulse", 1'b1, s)
		rd(A_CNT0, d);
		`CHK("latched", 32'h00020002, d)
		$display("test counter done");
		wr(A_ROUTE0 + 8'h01, 32'h0);
		wr(A_ROUTE0 + 8'h02, 32'h39);
		wr(A_UI, 32'h1);
		u_pfi_model.drive(9, 1'b1);
		wr(A_CTRL, 32'h0000ff10);
		u_pfi_model.pulse(3);
		fork
			repeat (4) u_pfi_model.pulse(9);
			cnt(80, n);
		join
		`CHK("ext clock", 2, n)
		wr(A_CTRL, 32'h0000ff02);
		$display("test clock done");
		close_out();
	end
endmodule
